// ### rtl/cas_pkg.sv
/*
  Constants for the codec audio serial master: frame layout, rates,
  slot and phase positions, buffer depth and handshake states.
  Assumes a single audio codec wired as a serial audio slave.
*/
package cas_pkg;

  // Frame rates
  localparam int unsigned SAMPLE_RATE_HZ   = 8000;
  localparam int unsigned MCLK_PER_FS      = 256;
  localparam int unsigned BCK_PER_FS       = 32;
  localparam int unsigned MCLK_HZ          = SAMPLE_RATE_HZ * MCLK_PER_FS;
  localparam int unsigned DEF_LINK_CLK_HZ  = 49152000;

  // Frame layout
  localparam int unsigned SAMPLE_BITS      = 16;
  localparam int unsigned CHANNELS         = 2;
  localparam int unsigned FRAME_BITS       = SAMPLE_BITS * CHANNELS;
  localparam int unsigned FIFO_DEPTH       = 32;

  // Bit clock phase: 16 master clock half periods per bit
  localparam int unsigned PH_W             = 4;
  localparam int unsigned BCK_PH_BIT       = 3;
  localparam logic [3:0]  PH_RISE          = 4'h7;
  localparam logic [3:0]  PH_FALL          = 4'hF;

  // Slots within one word select period
  localparam int unsigned SLOT_W           = 5;
  localparam int unsigned WS_SLOT_BIT      = 4;
  localparam logic [4:0]  SLOT_FIRST       = 5'h00;
  localparam logic [4:0]  SLOT_MSB         = 5'h01;

  // Left sample position within a received frame word
  localparam int unsigned RX_LEFT_HI       = 30;
  localparam int unsigned RX_LEFT_LO       = 15;

  // Speaker word handshake toward the link domain
  typedef enum logic [1:0] {
    CAS_HS_IDLE = 2'b01,
    CAS_HS_WAIT = 2'b10
  } cas_hs_state_t;

endpackage

// ### rtl/cas_sync.sv
/*
  Two flip-flop level synchroniser, parameterised width.
  Assumes each bit is a level or a toggle, never a multi-bit word.
*/
`timescale 1ns/1ps
module cas_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule

// ### rtl/cas_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and registered
  full/empty flags. Assumes one clock for both sides.
*/
`timescale 1ns/1ps
module cas_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d;
  logic [AW-1:0]    rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             in_rdy_q, in_rdy_d;
  logic             out_vld_q, out_vld_d;
  logic             push;
  logic             pop;

  always_comb
  begin
    push      = in_valid_in && in_rdy_q;
    pop       = out_vld_q && out_ready_in;
    wr_d      = wr_q;
    rd_d      = rd_q;
    cnt_d     = cnt_q;
    if (push)
      wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
    if (pop)
      rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
    in_rdy_d  = (cnt_d != CNT_FULL);
    out_vld_d = (cnt_d != '0);
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_rdy_q  <= 1'b1;
      out_vld_q <= 1'b0;
    end
    else
    begin
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      cnt_q     <= cnt_d;
      in_rdy_q  <= in_rdy_d;
      out_vld_q <= out_vld_d;
    end
  end

  // Storage, no reset
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_q] <= in_data_in;
  end

  assign in_ready_out  = in_rdy_q;
  assign out_valid_out = out_vld_q;
  assign out_data_out  = mem[rd_q];

endmodule

// ### rtl/cas_top.sv
/*
  Codec audio serial master: speaker FIFO and word handshake on the
  system clock, master clock, bit clock, word select and serial data
  on the link clock. Assumes the codec is a serial audio slave and the
  link clock is a free running multiple of the master clock.
*/
`timescale 1ns/1ps
// Overview of operation
// - Device drives bit clock and word select
// - Master clock output at 256 times rate
// - Standard framing, two 16-bit PCM channels
// - 8 kHz frames, 32 bit clocks each
// - Bit clock high and low halves equal
// - Left input slot is microphone sample
module cas_top #(
  parameter int unsigned LINK_CLK_HZ = cas_pkg::DEF_LINK_CLK_HZ,
  parameter int unsigned DIV_W       = 8,
  parameter int unsigned FIFO_DEPTH  = cas_pkg::FIFO_DEPTH
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        link_clk_in,
  input  wire logic [31:0] spk_data_in,
  input  wire logic        spk_valid_in,
  output logic             spk_ready_out,
  output logic      [15:0] mic_sample_out,
  output logic             mic_valid_out,
  output logic             codec_mclk_out,
  output logic             bit_clock_out,
  output logic             word_select_out,
  output logic             codec_sample_out,
  input  wire logic        codec_sample_in
);

  localparam int unsigned HALF_RAW  = LINK_CLK_HZ / (2 * cas_pkg::MCLK_HZ);
  localparam int unsigned MCLK_HALF = (HALF_RAW < 1) ? 1 : HALF_RAW;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MCLK_HALF - 1);
  localparam int BCK_HALF_CYC = 8 * MCLK_HALF;
  localparam int MCLK_HALF_CYC = MCLK_HALF;

  // System domain
  cas_pkg::cas_hs_state_t hs_q, hs_d;
  logic [31:0] tx_word_q, tx_word_d;
  logic        req_q, req_d;
  logic        rx_seen_q, rx_seen_d;
  logic [15:0] mic_q, mic_d;
  logic        mic_vld_q, mic_vld_d;
  logic        fifo_vld;
  logic        fifo_pop;
  logic [31:0] fifo_data;
  logic        ack_s;
  logic        rx_tgl_s;

  // Link domain
  logic             lrst_meta_q;
  logic             lrstn_q;
  logic [DIV_W-1:0] div_q, div_d;
  logic             mclk_q, mclk_d;
  logic [3:0]       ph_q, ph_d;
  logic             bck_q, bck_d;
  logic [4:0]       slot_q, slot_d;
  logic             ws_q, ws_d;
  logic             sdo_q, sdo_d;
  logic [31:0]      tx_sh_q, tx_sh_d;
  logic [31:0]      rx_sh_q, rx_sh_d;
  logic [15:0]      rx_left_q, rx_left_d;
  logic             rx_tgl_q, rx_tgl_d;
  logic             ack_q, ack_d;
  logic             req_s;
  logic             sdi_s;
  logic             tick;
  logic             bck_rise;
  logic             bck_fall;

  cas_fifo #(
    .WIDTH (cas_pkg::FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_spk_fifo (
    .clk_in        (ref_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (spk_valid_in),
    .in_ready_out  (spk_ready_out),
    .in_data_in    (spk_data_in),
    .out_valid_out (fifo_vld),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  cas_sync #(.W(2)) u_sync_sys (
    .clk_in  (ref_clk_in),
    .rstn_in (rstn_in),
    .d_in    ({ack_q, rx_tgl_q}),
    .q_out   ({ack_s, rx_tgl_s})
  );

  // Speaker word handoff and microphone capture
  always_comb
  begin
    hs_d      = hs_q;
    tx_word_d = tx_word_q;
    req_d     = req_q;
    fifo_pop  = 1'b0;
    rx_seen_d = rx_tgl_s;
    mic_d     = mic_q;
    mic_vld_d = 1'b0;
    case (hs_q)
      cas_pkg::CAS_HS_IDLE:
      begin
        if (fifo_vld)
        begin
          tx_word_d = fifo_data;
          req_d     = ~req_q;
          fifo_pop  = 1'b1;
          hs_d      = cas_pkg::CAS_HS_WAIT;
        end
      end
      cas_pkg::CAS_HS_WAIT:
      begin
        if (ack_s == req_q)
          hs_d = cas_pkg::CAS_HS_IDLE;
      end
      default:
        hs_d = cas_pkg::CAS_HS_IDLE;
    endcase
    if (rx_tgl_s != rx_seen_q)
    begin
      mic_d     = rx_left_q;
      mic_vld_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      hs_q      <= cas_pkg::CAS_HS_IDLE;
      tx_word_q <= '0;
      req_q     <= 1'b0;
      rx_seen_q <= 1'b0;
      mic_q     <= '0;
      mic_vld_q <= 1'b0;
    end
    else
    begin
      hs_q      <= hs_d;
      tx_word_q <= tx_word_d;
      req_q     <= req_d;
      rx_seen_q <= rx_seen_d;
      mic_q     <= mic_d;
      mic_vld_q <= mic_vld_d;
    end
  end

  assign mic_sample_out = mic_q;
  assign mic_valid_out  = mic_vld_q;

  // Link reset: asserted at once, released on the link clock
  always_ff @(posedge link_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      lrst_meta_q <= 1'b0;
      lrstn_q     <= 1'b0;
    end
    else
    begin
      lrst_meta_q <= 1'b1;
      lrstn_q     <= lrst_meta_q;
    end
  end

  cas_sync #(.W(2)) u_sync_link (
    .clk_in  (link_clk_in),
    .rstn_in (lrstn_q),
    .d_in    ({req_q, codec_sample_in}),
    .q_out   ({req_s, sdi_s})
  );

  // Clock generation and serial shifting
  always_comb
  begin
    tick      = (div_q == DIV_LAST);
    bck_rise  = tick && (ph_q == cas_pkg::PH_RISE);
    bck_fall  = tick && (ph_q == cas_pkg::PH_FALL);
    div_d     = tick ? '0 : div_q + 1'b1;
    mclk_d    = tick ? ~mclk_q : mclk_q;
    ph_d      = tick ? ph_q + 1'b1 : ph_q;
    bck_d     = ph_d[cas_pkg::BCK_PH_BIT];
    slot_d    = slot_q;
    ws_d      = ws_q;
    sdo_d     = sdo_q;
    tx_sh_d   = tx_sh_q;
    rx_sh_d   = rx_sh_q;
    rx_left_d = rx_left_q;
    rx_tgl_d  = rx_tgl_q;
    ack_d     = ack_q;
    if (bck_fall)
    begin
      slot_d  = slot_q + 1'b1;
      ws_d    = slot_d[cas_pkg::WS_SLOT_BIT];
      sdo_d   = tx_sh_q[31];
      tx_sh_d = {tx_sh_q[30:0], 1'b0};
      if (slot_d == cas_pkg::SLOT_FIRST)
      begin
        // New frame: fresh word or silence on underrun
        if (req_s != ack_q)
        begin
          tx_sh_d = tx_word_q;
          ack_d   = ~ack_q;
        end
        else
          tx_sh_d = '0;
      end
    end
    if (bck_rise)
    begin
      rx_sh_d = {rx_sh_q[30:0], sdi_s};
      if (slot_q == cas_pkg::SLOT_FIRST)
      begin
        rx_left_d = rx_sh_q[cas_pkg::RX_LEFT_HI:cas_pkg::RX_LEFT_LO];
        rx_tgl_d  = ~rx_tgl_q;
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge lrstn_q)
  begin
    if (!lrstn_q)
    begin
      div_q     <= '0;
      mclk_q    <= 1'b0;
      ph_q      <= '0;
      bck_q     <= 1'b0;
      slot_q    <= '0;
      ws_q      <= 1'b0;
      sdo_q     <= 1'b0;
      tx_sh_q   <= '0;
      rx_sh_q   <= '0;
      rx_left_q <= '0;
      rx_tgl_q  <= 1'b0;
      ack_q     <= 1'b0;
    end
    else
    begin
      div_q     <= div_d;
      mclk_q    <= mclk_d;
      ph_q      <= ph_d;
      bck_q     <= bck_d;
      slot_q    <= slot_d;
      ws_q      <= ws_d;
      sdo_q     <= sdo_d;
      tx_sh_q   <= tx_sh_d;
      rx_sh_q   <= rx_sh_d;
      rx_left_q <= rx_left_d;
      rx_tgl_q  <= rx_tgl_d;
      ack_q     <= ack_d;
    end
  end

  assign codec_mclk_out   = mclk_q;
  assign bit_clock_out    = bck_q;
  assign word_select_out  = ws_q;
  assign codec_sample_out = sdo_q;

  // Helper: link cycles since last edge of each generated clock
  logic [15:0] bck_run_q;
  logic [15:0] mclk_run_q;

  always_ff @(posedge link_clk_in or negedge lrstn_q)
  begin
    if (!lrstn_q)
    begin
      bck_run_q  <= '0;
      mclk_run_q <= '0;
    end
    else
    begin
      bck_run_q  <= (bck_d != bck_q) ? '0 : bck_run_q + 1'b1;
      mclk_run_q <= (mclk_d != mclk_q) ? '0 : mclk_run_q + 1'b1;
    end
  end

  sequence s_bck_falls;
    $fell(bit_clock_out);
  endsequence

  sequence s_frame_start;
    $changed(slot_q) && (slot_q == cas_pkg::SLOT_FIRST);
  endsequence

  AST_BCK_TOGGLES: assert property (@(posedge link_clk_in) disable iff (!lrstn_q)
    $rose(bit_clock_out) |-> ##[1:1000] $fell(bit_clock_out))
    else $error("bit clock stopped high");

  AST_MCLK_HALF: assert property (@(posedge link_clk_in) disable iff (!lrstn_q)
    $changed(codec_mclk_out) |-> $past(mclk_run_q) == 16'(MCLK_HALF_CYC - 1))
    else $error("master clock half period wrong");

  AST_BCK_DUTY: assert property (@(posedge link_clk_in) disable iff (!lrstn_q)
    ($changed(bit_clock_out) && $past(bit_clock_out) == 1'b1)
      |-> $past(bck_run_q) == 16'(BCK_HALF_CYC - 1))
    else $error("bit clock high half not equal to low half");

  AST_WS_AT_SLOT: assert property (@(posedge link_clk_in) disable iff (!lrstn_q)
    $changed(word_select_out)
      |-> $fell(bit_clock_out) && (slot_q[3:0] == 4'h0))
    else $error("word select moved away from a slot boundary");

  AST_SLOT_STEP: assert property (@(posedge link_clk_in) disable iff (!lrstn_q)
    s_bck_falls |-> slot_q == 5'($past(slot_q) + 5'h01))
    else $error("slot count did not step by one");

  AST_MSB_FIRST: assert property (@(posedge link_clk_in) disable iff (!lrstn_q)
    (s_bck_falls and (slot_q == cas_pkg::SLOT_MSB))
      |-> codec_sample_out == $past(tx_sh_q[31]))
    else $error("serial output not taken from shift register top");

  AST_WS_LEFT_LOW: assert property (@(posedge link_clk_in) disable iff (!lrstn_q)
    s_frame_start |-> !word_select_out)
    else $error("left slot not marked by low word select");

  AST_MIC_PULSE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    mic_valid_out |=> !mic_valid_out)
    else $error("microphone strobe longer than one cycle");

endmodule

// ### tb/cas_codec_model.sv
/*
  Behavioural audio codec slave for the serial master bench.
  Assumes bit clock and word select come from the device.
*/
`timescale 1ns/1ps
module cas_codec_model (
  input  wire logic        bit_clock_in,
  input  wire logic        word_select_in,
  input  wire logic        sdata_in,
  input  wire logic [15:0] left_in,
  output logic             sdata_out,
  output logic      [31:0] frame_out,
  output logic      [15:0] frames_out
);
  logic        ws_q = 1'b0;
  logic [3:0]  idx_q = 4'h0;
  logic [31:0] sh_q = 32'h0000_0000;

  initial
  begin
    sdata_out = 1'b0;
    frame_out = 32'h0000_0000;
    frames_out = 16'h0000;
  end

  // Slot position from word select edges, sampled on bit clock rise
  always @(posedge bit_clock_in)
  begin
    idx_q = (word_select_in != ws_q) ? 4'h0 : idx_q + 4'h1;
    ws_q = word_select_in;
    sh_q = {sh_q[30:0], sdata_in};
    if (!ws_q && idx_q == 4'h0)
    begin
      frame_out <= sh_q;
      frames_out <= frames_out + 16'h0001;
    end
  end

  // Right half carries the inverse, so stale bits never look valid
  always @(negedge bit_clock_in)
    sdata_out <= ws_q ^ left_in[4'hF - idx_q];
endmodule

// ### tb/tb_cas_top.sv
/*
  Self-checking bench for the codec audio serial master.
  Assumes a codec slave model on the link and 6 ns link clock.
*/
`timescale 1ns/1ps
module tb_cas_top;
  typedef struct packed
  {
    logic [31:0] spk;
    logic [15:0] mic;
  } cas_row_t;
  localparam int unsigned LINK_HZ = 16384000;
  localparam int unsigned MH      = LINK_HZ / (2 * cas_pkg::MCLK_HZ);

  logic        ref_clk_in = 1'b0;
  logic        link_clk_in = 1'b0;
  logic        rstn_in;
  logic [31:0] spk_data_in;
  logic        spk_valid_in;
  logic        spk_ready_out;
  logic [15:0] mic_sample_out;
  logic        mic_valid_out;
  logic        codec_mclk_out;
  logic        bit_clock_out;
  logic        word_select_out;
  logic        codec_sample_out;
  logic        codec_sample_in;
  logic [15:0] codec_left;
  logic [31:0] rx;
  logic [15:0] frames;
  logic        ok;
  logic [31:0] acc;
  logic [31:0] mc_len = 0, mc_run = 0, bk_len = 0, bk_hi = 0, bk_lo = 0;
  logic [31:0] falls = 0, ws_half = 0, ws_bad = 0;
  logic        mc_p = 0, bk_p = 0, ws_p = 0;
  int          err_count = 0;
  int          checked = 0;
  cas_row_t    rows [4] = '{'{32'h8001_7FFE, 16'h8000}, '{32'hFFFF_0000, 16'h0001},
                            '{32'h0000_FFFF, 16'hFFFF}, '{32'h1234_ABCD, 16'h5A3C}};

  always #25 ref_clk_in = ~ref_clk_in;
  initial
  begin
    #1.7;
    forever #3 link_clk_in = ~link_clk_in;
  end

  cas_top #(.LINK_CLK_HZ(LINK_HZ)) cas_top_i (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
    .spk_data_in(spk_data_in), .spk_valid_in(spk_valid_in), .spk_ready_out(spk_ready_out),
    .mic_sample_out(mic_sample_out), .mic_valid_out(mic_valid_out),
    .codec_mclk_out(codec_mclk_out), .bit_clock_out(bit_clock_out),
    .word_select_out(word_select_out), .codec_sample_out(codec_sample_out),
    .codec_sample_in(codec_sample_in));

  cas_codec_model cas_codec_model_i (
    .bit_clock_in(bit_clock_out), .word_select_in(word_select_out),
    .sdata_in(codec_sample_out), .left_in(codec_left), .sdata_out(codec_sample_in),
    .frame_out(rx), .frames_out(frames));

  // Level run lengths of master clock and bit clock in link cycles, word select in bit clock falls
  always @(posedge link_clk_in)
  begin
    mc_p <= codec_mclk_out;
    bk_p <= bit_clock_out;
    ws_p <= word_select_out;
    mc_len <= (codec_mclk_out !== mc_p) ? 1 : mc_len + 1;
    bk_len <= (bit_clock_out !== bk_p) ? 1 : bk_len + 1;
    if (codec_mclk_out !== mc_p)
      mc_run <= mc_len;
    if (bit_clock_out !== bk_p && bk_p)
      bk_hi <= bk_len;
    if (bit_clock_out !== bk_p && !bk_p)
      bk_lo <= bk_len;
    if (bk_p && !bit_clock_out)
    begin
      falls <= (word_select_out !== ws_p) ? 0 : falls + 1;
      if (word_select_out !== ws_p)
        ws_half <= falls + 1;
    end
    else if (word_select_out !== ws_p && rstn_in)
      ws_bad <= ws_bad + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_frame();
    logic [15:0] f;
    int          n;
    f = frames;
    n = 0;
    do
    begin
      @(negedge ref_clk_in);
      n++;
    end while (frames === f && n < 400);
    if (n >= 400)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask

  task automatic push(input logic [31:0] w, input int lim, output logic tk);
    int n;
    n = 0;
    spk_valid_in <= 1'b1;
    spk_data_in <= w;
    do
    begin
      @(negedge ref_clk_in);
      tk = (spk_ready_out === 1'b1);
      @(posedge ref_clk_in);
      n++;
    end while (!tk && n < lim);
  endtask

  task automatic wait_mic();
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk_in);
      n++;
    end while (mic_valid_out !== 1'b1 && n < 300);
  endtask

  initial
  begin
    repeat (30000) @(posedge ref_clk_in);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    rstn_in = 1'b0;
    spk_valid_in = 1'b0;
    spk_data_in = 32'h0000_0000;
    codec_left = 16'h0000;
    repeat (12) @(posedge ref_clk_in);
    check({26'h0, bit_clock_out, word_select_out, codec_mclk_out, codec_sample_out,
           mic_valid_out, spk_ready_out}, 32'h0000_0001);
    rstn_in <= 1'b1;
    wait_frame();
    wait_frame();
    for (int i = 0; i < 4; i++)
    begin
      wait_frame();
      @(posedge ref_clk_in);
      codec_left <= rows[i].mic;
      push(rows[i].spk, 50, ok);
      spk_valid_in <= 1'b0;
      wait_frame();
      wait_frame();
      check(rx, rows[i].spk);
      wait_mic();
      check({31'h0, mic_valid_out}, 32'h0000_0001);
      check({16'h0000, mic_sample_out}, {16'h0000, rows[i].mic});
      $display("row %0d done", i);
    end
    check(mc_run, MH);
    check(bk_hi, 8 * MH);
    check(bk_lo, 8 * MH);
    check(ws_half, 32'h0000_0010);
    check(ws_bad, 32'h0000_0000);
    $display("clock test done");
    wait_frame();
    @(posedge ref_clk_in);
    acc = 0;
    ok = 1'b1;
    for (int i = 0; i < 40 && ok; i++)
    begin
      push({16'hC000, 16'(i)}, 1, ok);
      acc = acc + {31'h0, ok};
    end
    push({16'hC000, acc[15:0]}, 20, ok);
    check(acc, 32'h0000_0021);
    check({31'h0, ok}, 32'h0000_0000);
    // Refused word stays offered until the next frame frees a place
    push({16'hC000, acc[15:0]}, 300, ok);
    spk_valid_in <= 1'b0;
    check({31'h0, ok}, 32'h0000_0001);
    for (int i = 0; i < 34; i++)
    begin
      wait_frame();
      check(rx, {16'hC000, 16'(i)});
    end
    wait_frame();
    check(rx, 32'h0000_0000);
    $display("fill and drain test done");
    @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    @(negedge ref_clk_in);
    check({26'h0, bit_clock_out, word_select_out, codec_mclk_out, codec_sample_out,
           mic_valid_out, spk_ready_out}, 32'h0000_0001);
    $display("reset test done");
    @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    push(rows[3].spk, 50, ok);
    spk_valid_in <= 1'b0;
    check({31'h0, ok}, 32'h0000_0001);
    for (int i = 0; i < 4 && rx !== rows[3].spk; i++)
      wait_frame();
    check(rx, rows[3].spk);
    $display("release test done");
    tally_and_finish();
  end
endmodule
